// >>> src/devcmd_pkg.sv
/*
 Constants, register map and carrier types for the device command register bank.
 Assumes a register access port from the serial interface front end on the same clock.
*/
package devcmd_pkg;
	localparam logic [7:0] OFS_DEVICE_COMMAND = 8'hea;
	localparam logic [7:0] OFS_ALGO_DEBUG = 8'hec;
	localparam logic [7:0] OFS_ALGO_SECOND = 8'hee;
	localparam logic [7:0] OFS_CURRENT_GAINS = 8'hf0;
	localparam logic [7:0] OFS_SPEED_GAINS = 8'hf2;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
	localparam int BIT_STORE = 31;
	localparam int BIT_RELOAD = 30;
	localparam int BIT_FAULT_CLR = 29;
	localparam int BIT_RETRY_CLR = 28;
	localparam int KEY_MSB = 27;
	localparam int KEY_LSB = 20;
	localparam int ANGLE_MSB = 19;
	localparam int ANGLE_LSB = 11;
	localparam int BIT_TICKLE = 10;
	localparam int BIT_FORCE_ALIGN_EN = 14;
	localparam logic [8:0] FULL_TURN = 9'h168;
	localparam logic [1:0] STARTUP_ALIGN = 2'h1;
	localparam logic [1:0] STARTUP_DOUBLE_ALIGN = 2'h2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic config_store;
		logic config_reload;
		logic fault_clear;
		logic retry_counter_clear;
		logic [7:0] write_key;
	} cmd_out_s;
endpackage

// >>> src/device_command_register.sv
/*
 Device command register and algorithm control register group.
 Assumes the serial interface front end presents single-cycle read and write
 strobes on mclk, and that the store/reload engine answers with a done pulse.
*/
`timescale 1ns/10ps

// Overview of operation
// - Setting bit 31 starts a configuration store into non-volatile memory.
// - Setting bit 30 starts a reload of default configuration from non-volatile memory.
// - Writing one to bit 29 clears faults, bit 28 clears retry counter.
// - Bits 27 to 20 carry the write key authorising non-volatile writes.
// - Bits 19 to 11 hold align angle, applied only in forced align state.
// - Applied align angle is the programmed value modulo 360 degrees.
// - Bit 10 is a readable, writable watchdog tickle bit for I2C mode.
// - Device clears the tickle bit back to zero by itself.
// - Command register sits at EAh, resets zero, bits 9 to 0 reserved.
// - Algorithm group at ECh, EEh, F0h, F2h, all resetting to zero.
// - Forced align held only with enable set and align-type startup method.
module device_command_register
	import devcmd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input devcmd_pkg::reg_req_s req,
	input wire logic nv_done,
	input wire logic [1:0] startup_method,
	input wire logic align_state_active,
	output devcmd_pkg::cmd_out_s cmd,
	output logic [31:0] rdata,
	output logic tickle_seen,
	output logic force_align_hold,
	output logic [8:0] align_angle,
	output logic [31:0] algorithm_debug_control,
	output logic [31:0] algorithm_control_second,
	output logic [31:0] current_loop_gains,
	output logic [31:0] speed_loop_gains
);
	import devcmd_pkg::*;

	logic [31:0] devcmd_q, devcmd_d;
	logic [31:0] algo_q [4];
	logic [31:0] algo_d [4];
	cmd_out_s cmd_q, cmd_d;
	logic [31:0] rdata_q, rdata_d;
	logic tickle_seen_q, tickle_seen_d;
	logic hold_q, hold_d;
	logic [8:0] angle_q, angle_d;
	logic [8:0] raw_angle;

	function automatic int algo_index(input logic [7:0] a);
		case (a)
			OFS_ALGO_DEBUG: algo_index = 0;
			OFS_ALGO_SECOND: algo_index = 1;
			OFS_CURRENT_GAINS: algo_index = 2;
			OFS_SPEED_GAINS: algo_index = 3;
			default: algo_index = -1;
		endcase
	endfunction

	assign raw_angle = devcmd_q[ANGLE_MSB:ANGLE_LSB];

	always_comb
	begin
		devcmd_d = devcmd_q;
		cmd_d = cmd_q;
		tickle_seen_d = 1'b0;
		cmd_d.fault_clear = 1'b0;
		cmd_d.retry_counter_clear = 1'b0;
		if (devcmd_q[BIT_TICKLE])
		begin
			devcmd_d[BIT_TICKLE] = 1'b0;
			tickle_seen_d = 1'b1;
		end
		// store/reload end when the engine reports done
		if (nv_done)
		begin
			devcmd_d[BIT_STORE] = 1'b0;
			devcmd_d[BIT_RELOAD] = 1'b0;
			cmd_d.config_store = 1'b0;
			cmd_d.config_reload = 1'b0;
		end
		// write at EAh; a new write wins over the clears above
		if (req.wr && req.addr == OFS_DEVICE_COMMAND)
		begin
			if (req.wdata[BIT_STORE])
			begin
				devcmd_d[BIT_STORE] = 1'b1;
				cmd_d.config_store = 1'b1;
			end
			if (req.wdata[BIT_RELOAD])
			begin
				devcmd_d[BIT_RELOAD] = 1'b1;
				cmd_d.config_reload = 1'b1;
			end
			cmd_d.fault_clear = req.wdata[BIT_FAULT_CLR];
			cmd_d.retry_counter_clear = req.wdata[BIT_RETRY_CLR];
			// key latched for the store engine
			cmd_d.write_key = req.wdata[KEY_MSB:KEY_LSB];
			devcmd_d[ANGLE_MSB:ANGLE_LSB] = req.wdata[ANGLE_MSB:ANGLE_LSB];
			devcmd_d[BIT_TICKLE] = req.wdata[BIT_TICKLE];
		end
	end

	// algorithm group writes; unlisted offsets are ignored
	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_algo
			always_comb
			begin
				algo_d[i] = algo_q[i];
				if (req.wr && algo_index(req.addr) == i)
					algo_d[i] = req.wdata;
			end
		end
	endgenerate

	always_comb
	begin
		rdata_d = rdata_q;
		if (req.rd)
		begin
			rdata_d = 32'h0000_0000;
			// readable bits only: triggers and tickle
			if (req.addr == OFS_DEVICE_COMMAND)
			begin
				rdata_d[BIT_STORE] = devcmd_q[BIT_STORE];
				rdata_d[BIT_RELOAD] = devcmd_q[BIT_RELOAD];
				rdata_d[BIT_TICKLE] = devcmd_q[BIT_TICKLE];
			end
			else if (algo_index(req.addr) > 0)
				rdata_d = algo_q[algo_index(req.addr)];
		end
	end

	always_comb
	begin
		hold_d = algo_q[0][BIT_FORCE_ALIGN_EN]
			&& (startup_method == STARTUP_ALIGN || startup_method == STARTUP_DOUBLE_ALIGN);
		angle_d = angle_q;
		// angle applied only in forced align
		if (hold_q && align_state_active)
		begin
			// wrap at one full turn; 9 bits never reach two turns
			if (raw_angle >= FULL_TURN)
				angle_d = raw_angle - FULL_TURN;
			else
				angle_d = raw_angle;
		end
	end

	// Command group: register image, command outputs and tickle pulse
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			devcmd_q <= RESET_VALUE;
			cmd_q <= '0;
			tickle_seen_q <= 1'b0;
		end
		else
		begin
			devcmd_q <= devcmd_d;
			cmd_q <= cmd_d;
			tickle_seen_q <= tickle_seen_d;
		end
	end

	// Algorithm group registers
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			for (int k = 0; k < 4; k++)
				algo_q[k] <= RESET_VALUE;
		end
		else
		begin
			for (int k = 0; k < 4; k++)
				algo_q[k] <= algo_d[k];
		end
	end

	// Read data is held between reads so a slow front end may fetch it late
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rdata_q <= RESET_VALUE;
		else
			rdata_q <= rdata_d;
	end

	// Align group: hold lags the enable by one cycle, angle follows the hold
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			hold_q <= 1'b0;
			angle_q <= 9'h000;
		end
		else
		begin
			hold_q <= hold_d;
			angle_q <= angle_d;
		end
	end

	assign cmd = cmd_q;
	assign rdata = rdata_q;
	assign tickle_seen = tickle_seen_q;
	assign force_align_hold = hold_q;
	assign align_angle = angle_q;
	assign algorithm_debug_control = algo_q[0];
	assign algorithm_control_second = algo_q[1];
	assign current_loop_gains = algo_q[2];
	assign speed_loop_gains = algo_q[3];
endmodule

// >>> test/devcmd_properties.sv
/* Port checker for the command register.
   Assumes a bind to the top module, rst active high. */
`timescale 1ns/10ps
module devcmd_props
	import devcmd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input devcmd_pkg::reg_req_s req,
	input devcmd_pkg::cmd_out_s cmd,
	input wire logic tickle_seen,
	input wire logic force_align_hold,
	input wire logic [8:0] align_angle,
	input wire logic [1:0] startup_method,
	input wire logic [31:0] algorithm_debug_control
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	wire ea = req.wr && req.addr == 8'hea;
	wire [31:0] d = req.wdata;
	chk_store_set: assert property (ea && d[31] |=> cmd.config_store)
		else $error("store late");
	chk_reload_set: assert property (ea && d[30] |=> cmd.config_reload)
		else $error("reload late");
	chk_fault_once: assert property (cmd.fault_clear == $past(ea && d[29]))
		else $error("fault pulse");
	chk_retry_once: assert property (cmd.retry_counter_clear == $past(ea && d[28]))
		else $error("retry pulse");
	chk_key_load: assert property (ea |=> cmd.write_key == $past(d[27:20]))
		else $error("key value");
	chk_tickle_clear: assert property (ea && d[10] |=> ##1 tickle_seen)
		else $error("tickle kept");
	chk_angle_wrap: assert property (align_angle < 9'h168)
		else $error("angle range");
	chk_angle_gate: assert property ($changed(align_angle) |-> $past(force_align_hold))
		else $error("angle ungated");
	chk_hold_follow: assert property (force_align_hold == $past(algorithm_debug_control[14] && (startup_method == STARTUP_ALIGN || startup_method == STARTUP_DOUBLE_ALIGN)))
		else $error("hold mismatch");
	cover property (cmd.fault_clear);
	cover property (tickle_seen);
	cover property (force_align_hold);
endmodule

// >>> test/nv_engine_model.sv
/* Store and reload engine model: done pulse after a held request.
   Assumes the block's mclk. */
`timescale 1ns/10ps
module nv_engine_model (
	input wire logic mclk,
	input wire logic busy,
	output logic nv_done
);
	logic [2:0] cnt_q, cnt_d;
	// Slow answer so the held request can be read back
	always_comb
		cnt_d = busy && !nv_done ? cnt_q + 3'h1 : 3'h0;
	always_ff @(posedge mclk)
		cnt_q <= cnt_d;
	assign nv_done = &cnt_q;
endmodule

// >>> test/tb_device_command_register.sv
/* Bench for the command register.
   Assumes the engine model answers on nv_done. */
`timescale 1ns/10ps
module tb_device_command_register;
	import devcmd_pkg::*;
	logic mclk = 1'b0, rst = 1'b1;
	reg_req_s req = '0;
	cmd_out_s cmd;
	logic nv_done, tickle_seen, force_align_hold;
	logic [8:0] align_angle;
	logic [31:0] rdata, rv;
	logic [1:0] startup_method = 2'h1;
	logic align_state_active = 1'b1;
	logic [31:0] algo_debug, algo_second, current_gains, speed_gains;
	int errors = 0, total_checks = 0;
	initial forever #12.5 mclk = ~mclk;
	device_command_register dut (.mclk, .rst, .req, .nv_done, .startup_method,
		.align_state_active, .cmd, .rdata, .tickle_seen, .force_align_hold,
		.align_angle, .algorithm_debug_control(algo_debug),
		.algorithm_control_second(algo_second), .current_loop_gains(current_gains),
		.speed_loop_gains(speed_gains));
	nv_engine_model eng (.mclk, .busy(cmd.config_store | cmd.config_reload), .nv_done);
	task automatic check(input logic [31:0] g, e);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	// One request per cycle; back to back calls never assign req twice
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		req = '{w, !w, a, wd};
		@(negedge mclk);
		rv = rdata;
	endtask
	task automatic print_verdict;
		$display("%0d checks %0d errors", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		for (logic [7:0] a = 8'hea; a != 8'hf6; a += 8'h2)
		begin
			xfer(1'b0, a, '0);
			check(rv, 32'h0);
			// Reserved offset F4 is only read, never written
			if (a != 8'hf4)
				xfer(1'b1, a, 32'h0ff0_0400);
			xfer(1'b0, a, '0);
			check(rv, a inside {8'hee, 8'hf0, 8'hf2} ? 32'h0ff0_0400 : 32'(a == 8'hea) << 10);
			check(32'(tickle_seen), 32'(a == 8'hea));
		end
		check(algo_debug, 32'h0ff0_0400);
		check(algo_second, 32'h0ff0_0400);
		check(current_gains, 32'h0ff0_0400);
		check(speed_gains, 32'h0ff0_0400);
		xfer(1'b1, 8'hea, 32'h3a50_0000);
		check(32'({cmd.fault_clear, cmd.retry_counter_clear, cmd.write_key}), 32'h3a5);
		for (int b = 30; b < 32; b++)
		begin
			xfer(1'b1, 8'hea, 32'h1 << b);
			check(32'({cmd.config_store, cmd.config_reload}), 32'h1 << (b - 30));
			for (int n = 0; n < 20 && nv_done !== 1'b1; n++)
				xfer(1'b0, 8'hea, '0);
			// A missing done pulse counts here and the run still reaches the verdict
			check(32'(nv_done), 32'h1);
			check(rv, 32'h1 << b);
			repeat (2) xfer(1'b0, 8'hea, '0);
			check(rv, 32'h0);
			check(32'({cmd.config_store, cmd.config_reload}), 32'h0);
		end
		xfer(1'b1, 8'hec, 32'h0000_4000);
		for (int a = 358; a < 362; a++)
		begin
			xfer(1'b1, 8'hea, 32'(a) << 11);
			repeat (3) xfer(1'b0, 8'hee, '0);
			check(32'(align_angle), 32'(a % 360));
		end
		check(32'(force_align_hold), 32'h1);
		// Angle must freeze while the algorithm is out of the align state
		align_state_active = 1'b0;
		xfer(1'b1, 8'hea, 32'h64 << 11);
		repeat (3) xfer(1'b0, 8'hee, '0);
		check(32'(align_angle), 32'h1);
		align_state_active = 1'b1;
		startup_method = 2'h2;
		repeat (3) xfer(1'b0, 8'hee, '0);
		check(32'(force_align_hold), 32'h1);
		check(32'(align_angle), 32'h64);
		startup_method = 2'h3;
		repeat (2) xfer(1'b0, 8'hee, '0);
		check(32'(force_align_hold), 32'h0);
		xfer(1'b1, 8'hea, 32'h0c8 << 11);
		repeat (3) xfer(1'b0, 8'hee, '0);
		check(32'(align_angle), 32'h64);
		xfer(1'b1, 8'hec, 32'h0);
		startup_method = 2'h1;
		repeat (2) xfer(1'b0, 8'hee, '0);
		check(32'(force_align_hold), 32'h0);
		check(algo_debug, 32'h0);
		print_verdict();
	end
endmodule
bind device_command_register devcmd_props props (.mclk, .rst, .req, .cmd,
	.tickle_seen, .force_align_hold, .align_angle, .startup_method, .algorithm_debug_control);
